// file: cgp_pkg.sv
package cgp_pkg;

  // register offsets within a page
  localparam logic [7:0] CGP_OFS_DIE_REVISION = 8'h00;
  localparam logic [7:0] CGP_OFS_PAGE_SELECT = 8'h01;
  localparam logic [7:0] CGP_OFS_PART_LOW = 8'h02;
  localparam logic [7:0] CGP_OFS_PART_HIGH = 8'h03;
  localparam logic [7:0] CGP_OFS_SPEED_GRADE = 8'h04;
  localparam logic [7:0] CGP_OFS_DEVICE_REVISION = 8'h05;
  localparam logic [7:0] CGP_OFS_TEMPERATURE_GRADE = 8'h09;
  localparam logic [7:0] CGP_OFS_PACKAGE_CODE = 8'h0A;
  localparam logic [7:0] CGP_OFS_BUS_ADDRESS_UPPER = 8'h0B;
  localparam logic [7:0] CGP_OFS_LIVE_STATUS = 8'h0C;
  localparam logic [7:0] CGP_OFS_INPUT_ABSENT_LIVE = 8'h0D;
  localparam logic [7:0] CGP_OFS_LATCHED_STATUS = 8'h11;
  localparam logic [7:0] CGP_OFS_INPUT_ABSENT_LATCHED = 8'h12;
  localparam logic [7:0] CGP_OFS_STATUS_IRQ_MASK = 8'h17;
  localparam logic [7:0] CGP_OFS_DEVICE_READY = 8'hFF;

  // the page that holds this bank
  localparam logic [7:0] CGP_HOME_PAGE = 8'h00;

  // field positions in status, latched and mask registers, and of the upper address field
  localparam int CGP_BIT_CALIBRATION = 0;
  localparam int CGP_BIT_CRYSTAL = 1;
  localparam int CGP_BIT_REFERENCE = 2;
  localparam int CGP_BIT_PLL = 3;
  localparam int CGP_BIT_TIMEOUT = 5;
  localparam int CGP_ADDR_UPPER_LSB = 2;
  localparam int CGP_ADDR_UPPER_MSB = 6;

  // implemented bits of the status group and input group
  localparam logic [7:0] CGP_STATUS_BITS = 8'h2F;
  localparam logic [7:0] CGP_INPUT_BITS = 8'h0F;

  // reset values
  localparam logic [7:0] CGP_RESET_PAGE = 8'h00;
  localparam logic [7:0] CGP_RESET_FLAGS = 8'h00;
  localparam logic [7:0] CGP_RESET_MASK = 8'h00;
  localparam logic [4:0] CGP_RESET_ADDR_UPPER = 5'h00;
  localparam logic [7:0] CGP_READ_ZERO = 8'h00;

  // encodings of identification fields
  localparam logic [7:0] CGP_TEMP_INDUSTRIAL = 8'h00;
  localparam logic [7:0] CGP_PACKAGE_64_LEAD = 8'h00;
  localparam logic [7:0] CGP_PACKAGE_44_LEAD = 8'h01;

  // largest codes the identification fields may carry
  localparam logic [3:0] CGP_DIE_REVISION_MAX = 4'h1;
  localparam logic [7:0] CGP_SPEED_GRADE_MAX = 8'h03;
  localparam logic [7:0] CGP_DEVICE_REVISION_MAX = 8'h01;

  // live detector levels from the analog side
  typedef struct packed {
    logic bus_timeout;
    logic pll_unlocked;
    logic reference_no_signal;
    logic crystal_no_signal;
    logic calibration_active;
  } cgp_status_s;

  // per-input clock absence: feedback, two, one, zero
  typedef struct packed {
    logic feedback_input;
    logic clock_input_two;
    logic clock_input_one;
    logic clock_input_zero;
  } cgp_input_absent_s;

endpackage

// file: cgp_regs.sv
`timescale 1ns/10ps
module cgp_regs
  import cgp_pkg::*;
#(
  // identification codes, fixed for each build of the bank
  parameter logic [3:0] DIE_REVISION = 4'h0,
  // arbitrary neutral identification value
  parameter logic [15:0] BASE_PART_DIGITS = 16'h1234,
  parameter logic [7:0] SPEED_GRADE = 8'h00,
  parameter logic [7:0] DEVICE_REVISION = 8'h00,
  parameter logic [7:0] PACKAGE_CODE = CGP_PACKAGE_64_LEAD
)
(
  input wire logic clk,
  input wire logic reset,
  // register port from the serial interface logic
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_offset,
  input wire logic [7:0] reg_write_data,
  output logic [7:0] reg_read_data,
  output logic [7:0] page_select,
  // detector levels and pins, asynchronous to clk
  input wire cgp_status_s status_live_pins,
  input wire cgp_input_absent_s input_clock_absent_pins,
  input wire logic device_ready_pin,
  input wire logic addr_select_pin_one,
  input wire logic addr_select_pin_zero,
  // address and interrupt pin outputs
  output logic [6:0] bus_target_address,
  output logic interrupt_out_n
);

  // elaboration checks; a code outside its documented set would read back
  // as a grade, revision or package that the host cannot decode
  if (DIE_REVISION > CGP_DIE_REVISION_MAX)
  begin : g_bad_die_revision
    $error("die revision must be 0 or 1");
  end

  if (SPEED_GRADE > CGP_SPEED_GRADE_MAX)
  begin : g_bad_speed_grade
    $error("speed grade code must be 0 to 3");
  end

  if (DEVICE_REVISION > CGP_DEVICE_REVISION_MAX)
  begin : g_bad_device_revision
    $error("device revision code must be 0 or 1");
  end

  if (PACKAGE_CODE > CGP_PACKAGE_44_LEAD)
  begin : g_bad_package_code
    $error("package code must be 0 or 1");
  end

  // the address field must fill the five upper address bits exactly
  if (CGP_ADDR_UPPER_MSB - CGP_ADDR_UPPER_LSB != 4)
  begin : g_bad_address_field
    $error("address field must be five bits wide");
  end

  // two-stage synchronisers for all detector and pin levels; they carry no
  // reset, so a level must stand two edges before the bank acts on it
  cgp_status_s status_meta, status_sync;
  cgp_input_absent_s absent_meta, absent_sync;
  logic [2:0] pins_meta, pins_sync;

  always_ff @(posedge clk)
  begin
    status_meta <= status_live_pins;
    status_sync <= status_meta;
    absent_meta <= input_clock_absent_pins;
    absent_sync <= absent_meta;
    pins_meta <= {device_ready_pin, addr_select_pin_one, addr_select_pin_zero};
    pins_sync <= pins_meta;
  end

  // synchronised pin levels under their own names
  logic ready_sync;
  logic [1:0] addr_pins_sync;
  assign ready_sync = pins_sync[2];
  assign addr_pins_sync = pins_sync[1:0];

  // live status as register images; unimplemented bits read zero
  logic [7:0] live_status;
  logic [7:0] input_clock_absent_live;
  always_comb
  begin
    live_status = CGP_READ_ZERO;
    live_status[CGP_BIT_CALIBRATION] = status_sync.calibration_active;
    live_status[CGP_BIT_CRYSTAL] = status_sync.crystal_no_signal;
    live_status[CGP_BIT_REFERENCE] = status_sync.reference_no_signal;
    live_status[CGP_BIT_PLL] = status_sync.pll_unlocked;
    live_status[CGP_BIT_TIMEOUT] = status_sync.bus_timeout;
    input_clock_absent_live = {4'h0, absent_sync};
  end

  // decode; page zero bank visible only on its own page
  logic on_home;
  logic wr_page, wr_addr, wr_latched, wr_absent, wr_mask;
  assign on_home = (page_select == CGP_HOME_PAGE);
  assign wr_page = reg_write && (reg_offset == CGP_OFS_PAGE_SELECT);
  // no write strobe exists for read-only offsets
  assign wr_addr = reg_write && on_home && (reg_offset == CGP_OFS_BUS_ADDRESS_UPPER);
  assign wr_latched = reg_write && on_home && (reg_offset == CGP_OFS_LATCHED_STATUS);
  assign wr_absent = reg_write && on_home && (reg_offset == CGP_OFS_INPUT_ABSENT_LATCHED);
  assign wr_mask = reg_write && on_home && (reg_offset == CGP_OFS_STATUS_IRQ_MASK);

  // offsets that answer on every page, whatever page is selected
  logic rd_page, rd_ready;
  assign rd_page = (reg_offset == CGP_OFS_PAGE_SELECT);
  assign rd_ready = (reg_offset == CGP_OFS_DEVICE_READY);

  // page select, reachable from every page
  always_ff @(posedge clk)
  begin
    if (reset)
      page_select <= CGP_RESET_PAGE;
    else if (wr_page)
      page_select <= reg_write_data;
  end

  // upper bus address bits
  logic [4:0] bus_address_upper;
  always_ff @(posedge clk)
  begin
    if (reset)
      bus_address_upper <= CGP_RESET_ADDR_UPPER;
    else if (wr_addr)
      bus_address_upper <= reg_write_data[CGP_ADDR_UPPER_MSB:CGP_ADDR_UPPER_LSB];
  end

  assign bus_target_address = {bus_address_upper, addr_pins_sync};

  // read image of the address register; unused bits read zero
  logic [7:0] bus_address_image;
  assign bus_address_image = {1'b0, bus_address_upper, 2'b00};

  // flags are level-set: a detector that stays high keeps its flag set,
  // so a clear only sticks once the condition has gone away; a set in the
  // clearing cycle wins, so an event that arrives meanwhile is never lost
  logic [7:0] status_set, status_clear;
  logic [7:0] absent_set, absent_clear;
  assign status_set = live_status & CGP_STATUS_BITS;
  assign absent_set = input_clock_absent_live & CGP_INPUT_BITS;

  assign status_clear = {8{wr_latched}} & ~reg_write_data & CGP_STATUS_BITS;
  assign absent_clear = {8{wr_absent}} & ~reg_write_data & CGP_INPUT_BITS;

  // flag vectors are nets so each bit can come from its own flop
  wire [7:0] latched_status_flags;
  wire [7:0] input_clock_absent_latched;

  for (genvar b = 0; b < 8; b++)
  begin : g_status_flag
    if (CGP_STATUS_BITS[b])
    begin : g_used
      logic flag;

      // one flop per implemented flag
      always_ff @(posedge clk)
      begin
        if (reset)
          flag <= CGP_RESET_FLAGS[b];
        else if (status_set[b])
          flag <= 1'b1;
        else if (status_clear[b])
          flag <= 1'b0;
      end

      assign latched_status_flags[b] = flag;
    end
    else
    begin : g_unused
      // unimplemented bit, reads zero
      assign latched_status_flags[b] = 1'b0;
    end
  end

  for (genvar b = 0; b < 8; b++)
  begin : g_absent_flag
    if (CGP_INPUT_BITS[b])
    begin : g_used
      logic flag;

      // one flop per input, cleared independently of the others
      always_ff @(posedge clk)
      begin
        if (reset)
          flag <= CGP_RESET_FLAGS[b];
        else if (absent_set[b])
          flag <= 1'b1;
        else if (absent_clear[b])
          flag <= 1'b0;
      end

      assign input_clock_absent_latched[b] = flag;
    end
    else
    begin : g_unused
      // unimplemented bit, reads zero
      assign input_clock_absent_latched[b] = 1'b0;
    end
  end

  // interrupt mask register; only bits with a matching status flag exist
  wire [7:0] status_interrupt_mask;
  for (genvar b = 0; b < 8; b++)
  begin : g_mask_bit
    if (CGP_STATUS_BITS[b])
    begin : g_used
      logic mask_bit;

      // mask bit written from the matching data bit
      always_ff @(posedge clk)
      begin
        if (reset)
          mask_bit <= CGP_RESET_MASK[b];
        else if (wr_mask)
          mask_bit <= reg_write_data[b];
      end

      assign status_interrupt_mask[b] = mask_bit;
    end
    else
    begin : g_unused
      assign status_interrupt_mask[b] = 1'b0;
    end
  end

  // unmasked status flags; the input flags have no mask bits
  // and do not reach this pin
  logic [7:0] irq_pending;
  assign irq_pending = latched_status_flags & ~status_interrupt_mask;

  // registered so the pin never glitches on decode
  always_ff @(posedge clk)
  begin
    if (reset)
      interrupt_out_n <= 1'b1;
    // active low while unmasked flag set
    else
      interrupt_out_n <= ~|irq_pending;
  end

  // page zero bank image; unknown offsets read zero
  logic [7:0] home_read_data;
  always_comb
  begin
    home_read_data = CGP_READ_ZERO;
    case (reg_offset)
      CGP_OFS_DIE_REVISION: home_read_data = {4'h0, DIE_REVISION};
      CGP_OFS_PART_LOW: home_read_data = BASE_PART_DIGITS[7:0];
      CGP_OFS_PART_HIGH: home_read_data = BASE_PART_DIGITS[15:8];
      CGP_OFS_SPEED_GRADE: home_read_data = SPEED_GRADE;
      CGP_OFS_DEVICE_REVISION: home_read_data = DEVICE_REVISION;
      CGP_OFS_TEMPERATURE_GRADE: home_read_data = CGP_TEMP_INDUSTRIAL;
      CGP_OFS_PACKAGE_CODE: home_read_data = PACKAGE_CODE;
      // upper address bits in place
      CGP_OFS_BUS_ADDRESS_UPPER: home_read_data = bus_address_image;
      // live detector levels
      CGP_OFS_LIVE_STATUS: home_read_data = live_status;
      // live per-input absence
      CGP_OFS_INPUT_ABSENT_LIVE: home_read_data = input_clock_absent_live;
      // sticky copies
      CGP_OFS_LATCHED_STATUS: home_read_data = latched_status_flags;
      CGP_OFS_INPUT_ABSENT_LATCHED: home_read_data = input_clock_absent_latched;
      // interrupt masks
      CGP_OFS_STATUS_IRQ_MASK: home_read_data = status_interrupt_mask;
      default: home_read_data = CGP_READ_ZERO;
    endcase
  end

  // read mux; page select and ready answer on every page, the rest of the
  // bank only while page zero is selected, other pages read zero
  logic [7:0] next_read_data;
  always_comb
  begin
    next_read_data = CGP_READ_ZERO;
    if (rd_page)
      next_read_data = page_select;
    else if (rd_ready)
      next_read_data = {7'h00, ready_sync};
    else if (on_home)
      next_read_data = home_read_data;
  end

  // read data held until the next read, so a slow serial port can shift
  // it out at its own pace
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_read_data <= CGP_READ_ZERO;
    else if (reg_read)
      reg_read_data <= next_read_data;
  end

endmodule

// file: cgp_regs_asserts.sv
`timescale 1ns/10ps
module cgp_regs_asserts
  import cgp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_offset,
  input wire logic [7:0] reg_write_data,
  input wire logic [7:0] reg_read_data,
  input wire logic [7:0] page_select,
  input wire cgp_status_s status_live_pins,
  input wire cgp_input_absent_s input_clock_absent_pins,
  input wire logic device_ready_pin,
  input wire logic addr_select_pin_one,
  input wire logic addr_select_pin_zero,
  input wire logic [6:0] bus_target_address,
  input wire logic interrupt_out_n
);
  logic [7:0] mask;
  logic [7:0] live;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // mask shadow, so irq timing can be judged without peeking inside
  always_ff @(posedge clk)
  begin
    if (reset)
      mask <= 8'h00;
    else if (reg_write && reg_offset == 8'h17 && page_select == 8'h00)
      mask <= reg_write_data & 8'h2F;
  end
  // status as it should read at 0x0C
  assign live = {2'h0, status_live_pins[4], 1'b0, status_live_pins[3:0]};
  AST_PAGE_WR: assert property (reg_write && reg_offset == 8'h01 |=> page_select == $past(reg_write_data))
    else $error("page not loaded");
  AST_PAGE_RD: assert property (reg_read && reg_offset == 8'h01 |=> reg_read_data == $past(page_select))
    else $error("page readback");
  AST_ADDR_PIN: assert property ($stable({addr_select_pin_one, addr_select_pin_zero})[*4]
    |-> bus_target_address[1:0] == {addr_select_pin_one, addr_select_pin_zero}) else $error("address pins");
  AST_LIVE_RD: assert property ($stable(status_live_pins)[*3] ##0 (reg_read && reg_offset == 8'h0C)
    |=> reg_read_data == (page_select == 8'h00 ? $past(live) : 8'h00)) else $error("live status");
  AST_LOS_RD: assert property ($stable(input_clock_absent_pins)[*3] ##0 (reg_read && reg_offset == 8'h0D)
    |=> reg_read_data == (page_select == 8'h00 ? {4'h0, $past(input_clock_absent_pins)} : 8'h00)) else $error("absence");
  AST_READY: assert property ($stable(device_ready_pin)[*3] ##0 (reg_read && reg_offset == 8'hFF)
    |=> reg_read_data == {7'h00, $past(device_ready_pin)}) else $error("ready bit");
  AST_IRQ_SET: assert property (((live & ~mask) != 8'h00)[*5] |-> !interrupt_out_n) else $error("irq missing");
  AST_IRQ_MASK: assert property ((mask == 8'h2F)[*3] |-> interrupt_out_n) else $error("irq not masked");
endmodule

// file: cgp_host_model.sv
`timescale 1ns/10ps
module cgp_host_model
  import cgp_pkg::*;
(
  input wire logic clk,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_offset,
  output logic [7:0] reg_write_data
);
  logic [7:0] exp_q [$];
  // idle bus at power up
  initial
  begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_offset = 8'h00;
    reg_write_data = 8'h00;
  end
  // one-edge strobe
  // strobes drop low; released offset and data show the inverse, never a stale value
  task automatic acc(input logic w, input logic [7:0] o, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_write = w;
    reg_read = !w;
    reg_offset = o;
    reg_write_data = d;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    #1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_offset = ~o;
    reg_write_data = ~d;
  endtask
endmodule

// file: clockgen_page0_status_id_regs_test.sv
`timescale 1ns/10ps
module clockgen_page0_status_id_regs_test
  import cgp_pkg::*;
;
  logic clk, reset, reg_write, reg_read, device_ready_pin, addr_select_pin_one, addr_select_pin_zero;
  logic interrupt_out_n;
  logic pend = 1'b0;
  logic [7:0] reg_offset, reg_write_data, reg_read_data, page_select, a;
  logic [6:0] bus_target_address;
  logic [31:0] rnd;
  cgp_status_s status_live_pins;
  cgp_input_absent_s input_clock_absent_pins;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] ofs [15] = '{8'h01, 8'h0B, 8'h11, 8'h12, 8'h17, 8'h00, 8'h02, 8'h03,
    8'h04, 8'h05, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h40};
  cgp_regs u_cgp_regs (.clk, .reset, .reg_write, .reg_read, .reg_offset, .reg_write_data, .reg_read_data,
    .page_select, .status_live_pins, .input_clock_absent_pins, .device_ready_pin, .addr_select_pin_one,
    .addr_select_pin_zero, .bus_target_address, .interrupt_out_n);
  cgp_host_model u_cgp_host_model (.clk, .reg_write, .reg_read, .reg_offset, .reg_write_data);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [7:0] exv(input int i);
    return i == 6 ? 8'h34 : (i == 7 ? 8'h12 : 8'h00);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    u_cgp_host_model.acc(1'b1, o, d);
  endtask
  task automatic rd(input logic [7:0] o, input logic [7:0] e);
    u_cgp_host_model.acc(1'b0, o, e);
  endtask
  task automatic wrd(input logic [7:0] o, input logic [7:0] d, input logic [7:0] e);
    wr(o, d);
    rd(o, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // read data lands one edge after the strobe; a hang ends the run
  always @(posedge clk)
  begin
    if (pend)
      chk(reg_read_data, u_cgp_host_model.exp_q.pop_front());
    pend = reg_read;
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    reset = 1'b1;
    status_live_pins = '0;
    input_clock_absent_pins = '0;
    device_ready_pin = 1'b1;
    addr_select_pin_one = 1'b1;
    addr_select_pin_zero = 1'b0;
    rnd = 32'h45a7dca6;
    idle(3);
    reset = 1'b0;
    chk({7'h00, interrupt_out_n}, 8'h01);
    foreach (ofs[i])
      rd(ofs[i], exv(i));
    for (int i = 5; i < 15; i++)
      wrd(ofs[i], 8'hFF, exv(i));
    rnd = xs(rnd);
    a = rnd[7:0];
    wrd(8'h0B, a, a & 8'h7C);
    idle(4);
    chk({1'b0, bus_target_address}, {1'b0, a[6:2], 2'b10});
    addr_select_pin_one = 1'b0;
    addr_select_pin_zero = 1'b1;
    idle(4);
    chk({1'b0, bus_target_address}, {1'b0, a[6:2], 2'b01});
    // random detector patterns, then mask, release and clear
    repeat (6)
    begin
      rnd = xs(rnd);
      status_live_pins = rnd[4:0];
      input_clock_absent_pins = rnd[11:8];
      idle(5);
      chk({7'h00, interrupt_out_n}, {7'h00, rnd[4:0] == 5'h00});
      rd(8'h0C, {2'h0, rnd[4], 1'b0, rnd[3:0]});
      rd(8'h0D, {4'h0, rnd[11:8]});
      wr(8'h17, 8'hFF);
      idle(3);
      chk({7'h00, interrupt_out_n}, 8'h01);
      wrd(8'h17, 8'h00, 8'h00);
      status_live_pins = '0;
      input_clock_absent_pins = '0;
      idle(4);
      wrd(8'h11, 8'hFF, {2'h0, rnd[4], 1'b0, rnd[3:0]});
      wrd(8'h12, 8'h0E, {4'h0, rnd[11:9], 1'b0});
      wrd(8'h12, 8'h00, 8'h00);
      wrd(8'h11, 8'h00, 8'h00);
      rd(8'h0D, 8'h00);
      chk({7'h00, interrupt_out_n}, 8'h01);
    end
    rd(8'hFF, 8'h01);
    status_live_pins = '1;
    wrd(8'h01, 8'h05, 8'h05);
    rd(8'h0C, 8'h00);
    wr(8'h0B, 8'h00);
    device_ready_pin = 1'b0;
    idle(3);
    rd(8'hFF, 8'h00);
    wrd(8'h01, 8'hFF, 8'hFF);
    wrd(8'h01, 8'h00, 8'h00);
    rd(8'h0B, a & 8'h7C);
    idle(2);
    summarize();
  end
endmodule
bind cgp_regs cgp_regs_asserts u_chk (.clk, .reset, .reg_write, .reg_read, .reg_offset, .reg_write_data,
  .reg_read_data, .page_select, .status_live_pins, .input_clock_absent_pins, .device_ready_pin,
  .addr_select_pin_one, .addr_select_pin_zero, .bus_target_address, .interrupt_out_n);
